// ===== include/qsr_defs.vh
// Constants for the quad recirculating shift register.
// Assumes inclusion by bare name from the design files.
`ifndef QSR_DEFS_VH
`define QSR_DEFS_VH
`define QSR_LEN_LONG 80
`define QSR_LEN_SHORT 64
`define QSR_LANES 4
`define QSR_FIFO_DEPTH 8
`define QSR_FIFO_AW 3
`define QSR_CLK_HZ 50000000
`endif

// ===== rtl/qsr_fifo.v
// Small synchronous FIFO built from flip-flops, valid/ready on both sides.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module qsr_fifo #(
	parameter WIDTH = 4,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire i_mclk,
	input wire i_rst,
	input wire i_in_valid,
	output wire o_in_ready,
	input wire [WIDTH-1:0] i_in_data,
	output wire o_out_valid,
	input wire i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	integer k;
	assign o_in_ready = (cnt_q != DEPTH[AW:0]);
	assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
	assign o_out_data = mem_q[rd_q];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;
	always @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			for (k = 0; k < DEPTH; k = k + 1)
				mem_q[k] <= {WIDTH{1'b0}};
		end
		else
		begin
			if (push)
			begin
				mem_q[wr_q] <= i_in_data;
				wr_q <= wr_q + 1'b1;
			end
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/qsr_top.v
// Four recirculating serial shift registers stepped by one external clock.
// Assumes the shift clock, data and select pins are asynchronous to i_mclk.
// Expects i_mclk far faster than the shift clock; each phase needs several cycles.
// Outputs come straight from flip-flops; lane storage holds no reset.
`timescale 1ns/100ps
`default_nettype none
`include "qsr_defs.vh"
module qsr_top #(
	parameter LONG_VARIANT = 1
) (
	input wire i_mclk,
	input wire i_rst,
	input wire i_shift_clk,
	input wire [3:0] i_sdata,
	input wire [3:0] i_recirc,
	output wire [3:0] o_sdata,
	output wire o_stall
);
	localparam LEN = LONG_VARIANT ? `QSR_LEN_LONG : `QSR_LEN_SHORT;
	localparam NL = `QSR_LANES;
	localparam W = 2 * NL;
	localparam DEPTH = `QSR_FIFO_DEPTH;
	localparam AW = `QSR_FIFO_AW;

	// Shift clock sampler; the two later stages must agree before a level counts
	reg clk_a_q;
	reg clk_b_q;
	reg clk_c_q;
	reg clk_lvl_q;
	reg clk_lvl_d;
	wire clk_agree;
	wire fall;

	always @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
		begin
			clk_a_q <= 1'b0;
			clk_b_q <= 1'b0;
			clk_c_q <= 1'b0;
			clk_lvl_q <= 1'b0;
		end
		else
		begin
			clk_a_q <= i_shift_clk;
			clk_b_q <= clk_a_q;
			clk_c_q <= clk_b_q;
			clk_lvl_q <= clk_lvl_d;
		end
	end

	assign clk_agree = (clk_b_q == clk_c_q);

	always @*
	begin
		clk_lvl_d = clk_lvl_q;
		if (clk_agree)
			clk_lvl_d = clk_c_q;
	end

	// Level starts low, so a clock idling high after reset makes no false fall
	assign fall = clk_agree & ~clk_c_q & clk_lvl_q;

	// Data and select pins, sampled three deep like the clock
	wire [W-1:0] pin_raw;
	wire [W-1:0] pin_lvl;

	assign pin_raw = {i_recirc, i_sdata};

	genvar p;
	generate
		for (p = 0; p < W; p = p + 1)
		begin : pin
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg lvl_q;
			reg lvl_d;
			wire agree;

			assign agree = (s2_q == s3_q);

			always @(posedge i_mclk or posedge i_rst)
			begin
				if (i_rst)
				begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					lvl_q <= 1'b0;
				end
				else
				begin
					s1_q <= pin_raw[p];
					s2_q <= s1_q;
					s3_q <= s2_q;
					lvl_q <= lvl_d;
				end
			end

			always @*
			begin
				lvl_d = lvl_q;
				if (agree)
					lvl_d = s3_q;
			end

			assign pin_lvl[p] = lvl_q;
		end
	endgenerate

	// Edges queue here so a burst is not lost if the shifter stalls
	wire f_in_ready;
	wire f_out_valid;
	wire f_out_ready;
	wire [W-1:0] f_out_data;
	reg stall_q;
	reg stall_d;

	// Lanes take an edge at once, so the queue never fills in normal use
	assign f_out_ready = 1'b1;

	qsr_fifo #(
		.WIDTH(W),
		.DEPTH(DEPTH),
		.AW(AW)
	) u_fifo (
		.i_mclk(i_mclk),
		.i_rst(i_rst),
		.i_in_valid(fall),
		.o_in_ready(f_in_ready),
		.i_in_data(pin_lvl),
		.o_out_valid(f_out_valid),
		.i_out_ready(f_out_ready),
		.o_out_data(f_out_data)
	);

	always @*
	begin
		stall_d = ~f_in_ready;
	end

	// A full queue would drop edges; the flag only reports such misuse
	always @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			stall_q <= 1'b0;
		else
			stall_q <= stall_d;
	end

	assign o_stall = stall_q;

	// Storage has no reset on purpose: contents are whatever was shifted in
	genvar g;
	generate
		for (g = 0; g < NL; g = g + 1)
		begin : lane
			reg [LEN-1:0] sr_q;
			reg [LEN-1:0] sr_d;
			reg out_q;
			reg out_d;
			reg in_bit;

			wire sel_recirc;
			wire new_bit;
			wire top_bit;

			assign sel_recirc = f_out_data[NL + g];
			assign new_bit = f_out_data[g];
			assign top_bit = sr_q[LEN-1];

			// The leaving bit feeds back, so LEN edges return the same word
			always @*
			begin
				case (sel_recirc)
				1'b1:
					in_bit = top_bit;
				default:
					in_bit = new_bit;
				endcase
			end

			always @*
			begin
				sr_d = sr_q;
				if (f_out_valid)
					sr_d = {sr_q[LEN-2:0], in_bit};
			end

			always @(posedge i_mclk)
			begin
				sr_q <= sr_d;
			end

			// Output mirrors the new last stage, so recirculation stays visible
			always @*
			begin
				out_d = out_q;
				if (f_out_valid)
					out_d = sr_d[LEN-1];
			end

			always @(posedge i_mclk or posedge i_rst)
			begin
				if (i_rst)
					out_q <= 1'b0;
				else
					out_q <= out_d;
			end

			assign o_sdata[g] = out_q;
		end
	endgenerate
endmodule
`default_nettype wire

// ===== sim/qsr_top_properties.sv
// Port checker for qsr_top.
// Assumes shifts are spaced by the driver.
`timescale 1ns/100ps
`default_nettype none
module qsr_top_properties (
	input wire i_mclk,
	input wire i_rst,
	input wire i_shift_clk,
	input wire [3:0] o_sdata,
	input wire o_stall
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	out_cleared_a: assert property ($fell(i_rst) |-> $past(o_sdata) == 4'h0)
		else $error("output not clear in reset");
	no_stall_a: assert property (!o_stall)
		else $error("edge queue stalled");
	// Long high phase: the last fall has already landed
	quiet_hold_a: assert property (i_shift_clk [*8] |=> $stable(o_sdata))
		else $error("output moved without shift");
	reset_clear_a: assert property (disable iff (1'b0) i_rst |=> (o_sdata == 4'h0) && !o_stall)
		else $error("outputs not clear during reset");
	edge_only_a: assert property ($changed(o_sdata) |-> !$past(i_shift_clk, 3))
		else $error("output moved outside a shift");
	low_hold_a: assert property (!i_shift_clk [*8] |=> $stable(o_sdata))
		else $error("output moved while clock held low");
	cover property ($fell(i_shift_clk));
	cover property ($changed(o_sdata));
	cover property (i_shift_clk [*8]);
endmodule
`default_nettype wire

// ===== sim/qsr_driver.sv
// Far-side logic driving shift clock, data and selects.
// Assumes i_mclk is the 50 MHz bench clock.
`timescale 1ns/100ps
`default_nettype none
module qsr_driver (
	input wire i_mclk,
	output logic o_shift_clk = 1'b1,
	output logic [3:0] o_sdata = 4'h0,
	output logic [3:0] o_recirc = 4'h0
);
	event done;
	// Spacing covers the 3-flop filter plus setup and hold
	task automatic shift(input logic [3:0] d, input logic [3:0] r);
		@(posedge i_mclk) o_sdata <= d;
		o_recirc <= r;
		repeat (4) @(posedge i_mclk);
		o_shift_clk <= 1'b0;
		repeat (8) @(posedge i_mclk);
		->done;
		o_shift_clk <= 1'b1;
		repeat (4) @(posedge i_mclk);
	endtask
endmodule
`default_nettype wire

// ===== sim/qsr_top_bench.sv
// Self-checking bench for qsr_top.
// Assumes the driver model and checker files.
`timescale 1ns/100ps
`default_nettype none
module qsr_top_bench;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	wire sck;
	wire [3:0] sd;
	wire [3:0] rc;
	wire [3:0] o_sdata;
	wire o_stall;
	int n_fail = 0;
	int cmp_count = 0;
	logic [79:0] lane [4];
	logic [3:0] expq [$];
	always #10 i_mclk = ~i_mclk;
	qsr_driver u_drv (.i_mclk(i_mclk), .o_shift_clk(sck), .o_sdata(sd), .o_recirc(rc));
	qsr_top u_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_shift_clk(sck), .i_sdata(sd),
		.i_recirc(rc), .o_sdata(o_sdata), .o_stall(o_stall));
	task automatic step(input logic [3:0] d, input logic [3:0] r);
		logic [3:0] e;
		for (int k = 0; k < 4; k++)
		begin
			lane[k] = {lane[k][78:0], r[k] ? lane[k][79] : d[k]};
			e[k] = lane[k][79];
		end
		expq.push_back(e);
		u_drv.shift(d, r);
	endtask
	task automatic check_sdata(input logic [3:0] e);
		cmp_count++;
		if (o_sdata !== e)
		begin
			n_fail++;
			$display("CHECK FAILED o_sdata exp %h got %h", e, o_sdata);
		end
	endtask
	task automatic check_stall();
		cmp_count++;
		if (o_stall !== 1'b0)
		begin
			n_fail++;
			$display("CHECK FAILED o_stall exp 0 got %b", o_stall);
		end
	endtask
	// Unfilled stages are unknown, so those shifts check o_stall but not o_sdata
	always @(u_drv.done)
	begin
		logic [3:0] e;
		e = expq.pop_front();
		check_stall();
		if (!$isunknown(e))
			check_sdata(e);
	end
	task automatic give_verdict();
		$display("compares %0d fails %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge i_mclk);
		n_fail++;
		give_verdict();
	end
	initial
	begin
		void'($urandom(44));
		repeat (20) @(posedge i_mclk);
		i_rst <= 1'b0;
		repeat (80) step(4'($urandom), 4'h0);
		$display("fill done");
		repeat (100) step(4'($urandom), 4'($urandom));
		$display("mixed done");
		repeat (80) step(4'($urandom), 4'hf);
		$display("recirculate done");
		give_verdict();
	end
endmodule
bind qsr_top qsr_top_properties u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
	.i_shift_clk(i_shift_clk), .o_sdata(o_sdata), .o_stall(o_stall));
`default_nettype wire
